//--- core/fbd_regs.svh
// bit positions, reset values and timing counts of the command and state words
`ifndef FBD_REGS_SVH
`define FBD_REGS_SVH
`define FBD_CW_ON 0
`define FBD_CW_COAST_N 1
`define FBD_CW_QSTOP_N 2
`define FBD_CW_START 3
`define FBD_CW_RAMP_ZERO_N 4
`define FBD_CW_RAMP_HOLD_N 5
`define FBD_CW_SETP_EN 6
`define FBD_CW_FAULT_ACK 7
`define FBD_CW_JOG1 8
`define FBD_CW_JOG2 9
`define FBD_CW_FB_EN 10
`define FBD_CW_ALIVE 11
`define FBD_SC_RUN 0
`define FBD_SC_DIR 1
`define FBD_SC_FRST 2
`define FBD_SW_RDY_ON 0
`define FBD_SW_RDY_RUN 1
`define FBD_SW_RUNNING 2
`define FBD_SW_FAULT 3
`define FBD_SW_COAST_N 4
`define FBD_SW_QSTOP_N 5
`define FBD_SW_INHIBIT 6
`define FBD_SW_WARN 7
`define FBD_SW_AT_REF 8
`define FBD_SW_FB_ACT 9
`define FBD_SW_ABOVE 10
`define FBD_SW_ECHO 15
`define FBD_WORD_RESET 16'h0000
// one timeout unit is 1 ms
`define FBD_TICK_NS 1000000
`define FBD_CLK_NS 10
`define FBD_TICK_CYCLES (`FBD_TICK_NS / `FBD_CLK_NS)
`endif

//--- core/fbd_pkg.sv
// types shared by the fieldbus command/status block
package fbd_pkg;
  typedef enum logic [1:0] {
    FBD_SEL_NONE,
    FBD_SEL_JOG1,
    FBD_SEL_JOG2
  } fbd_jog_type;
endpackage

//--- core/fbd_alive_watch.sv
// alive pulse watchdog counting the time since the last toggle
`timescale 1ns/100ps
`include "fbd_regs.svh"
module fbd_alive_watch #(
  parameter int TICK_CYCLES = `FBD_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic alive_bit,
  input wire logic [15:0] alive_pulse_timeout_setting,
  output logic timeout
);
  logic alive_last_reg;
  logic [31:0] tick_cnt_reg;
  logic [15:0] ms_cnt_reg;
  logic toggled;
  logic disabled;

  assign toggled = alive_bit != alive_last_reg;
  assign disabled = alive_pulse_timeout_setting == 16'h0000;

  always_ff @(posedge sys_clk) begin
    if (rst)
      alive_last_reg <= 1'b0;
    else if (ce)
      alive_last_reg <= alive_bit;
  end

  // a toggle restarts the window; setting zero holds it idle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_cnt_reg <= 32'h0000_0000;
      ms_cnt_reg <= 16'h0000;
    end else if (ce) begin
      if (toggled || disabled) begin
        tick_cnt_reg <= 32'h0000_0000;
        ms_cnt_reg <= 16'h0000;
      end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
        tick_cnt_reg <= 32'h0000_0000;
        if (ms_cnt_reg != 16'hffff)
          ms_cnt_reg <= ms_cnt_reg + 16'h0001;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst)
      timeout <= 1'b0;
    else if (ce)
      timeout <= !disabled &&
        ms_cnt_reg >= alive_pulse_timeout_setting;
  end
endmodule

//--- core/fbd_speed_cmp.sv
// speed comparisons for at-reference and above-limit flags
`timescale 1ns/100ps
module fbd_speed_cmp (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic signed [15:0] speed_actual,
  input wire logic signed [15:0] speed_reference,
  input wire logic [15:0] speed_tolerance,
  input wire logic [15:0] upper_speed_threshold,
  output logic at_reference,
  output logic above_limit
);
  logic [16:0] err_mag;
  logic [15:0] act_mag;
  logic signed [16:0] diff;

  assign diff = 17'(speed_actual) - 17'(speed_reference);
  assign err_mag = diff[16] ? 17'(-diff) : 17'(diff);
  // magnitude so that either direction counts against the limit
  assign act_mag = speed_actual[15] ? 16'(-speed_actual) : speed_actual;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      at_reference <= 1'b0;
      above_limit <= 1'b0;
    end else if (ce) begin
      at_reference <= err_mag <= {1'b0, speed_tolerance};
      above_limit <= act_mag > upper_speed_threshold;
    end
  end
endmodule

//--- core/fbd_cmd_status.sv
// fieldbus command word decoder and state word builder
`timescale 1ns/100ps
`include "fbd_regs.svh"
module fbd_cmd_status #(
  parameter int TICK_CYCLES = `FBD_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [15:0] fieldbus_command_word,
  input wire logic [15:0] simple_command_word,
  input wire logic simple_mode,
  input wire logic fieldbus_place,
  input wire logic aux_jog_enable,
  input wire logic io_jog_enable,
  input wire logic terminal_control,
  input wire logic [15:0] alive_pulse_timeout_setting,
  input wire logic powered_ready,
  input wire logic modulating,
  input wire logic flux_ready,
  input wire logic brake_feedback_used,
  input wire logic brake_open,
  input wire logic warning_in,
  input wire logic fault_in,
  input wire logic at_zero_speed,
  input wire logic signed [15:0] speed_actual,
  input wire logic signed [15:0] speed_reference,
  input wire logic [15:0] speed_tolerance,
  input wire logic [15:0] upper_speed_threshold,
  output logic [15:0] fieldbus_state_word,
  output logic run_request,
  output logic direction_ccw,
  output logic coast_stop,
  output logic quick_stop,
  output logic fault_reset,
  output logic jog1_active,
  output logic jog2_active,
  output logic fault_active,
  output logic alive_fault
);
  logic [15:0] cw;
  logic fb_en;
  logic fb_en_last_reg;
  logic frst_last_reg;
  logic ack_last_reg;
  logic fault_reg;
  logic inhibit_reg;
  logic released_reg;
  logic on_last_reg;
  logic jog_ok;
  logic timeout;
  logic at_reference;
  logic above_limit;
  logic running_ok;
  logic ready_on;
  logic ready_run;
  fbd_pkg::fbd_jog_type jog_sel_reg;
  fbd_pkg::fbd_jog_type jog_next;

  function automatic logic cw_bit(input logic [15:0] w, input int pos);
    cw_bit = w[pos[3:0]];
  endfunction

  assign cw = fieldbus_command_word;
  assign fb_en = cw_bit(cw, `FBD_CW_FB_EN) && !simple_mode;

  // a short tick lets a bench reach the timeout in a few cycles
  fbd_alive_watch #(.TICK_CYCLES(TICK_CYCLES)) u_alive (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .alive_bit(cw_bit(cw, `FBD_CW_ALIVE)),
    .alive_pulse_timeout_setting(alive_pulse_timeout_setting),
    .timeout(timeout)
  );

  fbd_speed_cmp u_speed (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .speed_actual(speed_actual),
    .speed_reference(speed_reference),
    .speed_tolerance(speed_tolerance),
    .upper_speed_threshold(upper_speed_threshold),
    .at_reference(at_reference),
    .above_limit(above_limit)
  );

  assign alive_fault = timeout;
  assign running_ok = modulating && flux_ready &&
    (!brake_feedback_used || brake_open);

  // jog enable source depends on control place
  assign jog_ok = terminal_control ? io_jog_enable : aux_jog_enable;

  always_comb begin
    jog_next = jog_sel_reg;
    if (!fb_en || !jog_ok || !cw_bit(cw, `FBD_CW_START) ||
        cw_bit(cw, `FBD_CW_RAMP_ZERO_N) || cw_bit(cw, `FBD_CW_RAMP_HOLD_N) ||
        cw_bit(cw, `FBD_CW_SETP_EN)) begin
      jog_next = fbd_pkg::FBD_SEL_NONE;
    end else if (cw_bit(cw, `FBD_CW_JOG1) && cw_bit(cw, `FBD_CW_JOG2)) begin
      // both jogs together means stop
      jog_next = fbd_pkg::FBD_SEL_NONE;
    end else if (jog_sel_reg == fbd_pkg::FBD_SEL_NONE) begin
      if (at_zero_speed && cw_bit(cw, `FBD_CW_JOG1))
        jog_next = fbd_pkg::FBD_SEL_JOG1;
      else if (at_zero_speed && cw_bit(cw, `FBD_CW_JOG2))
        jog_next = fbd_pkg::FBD_SEL_JOG2;
    end else if (!cw_bit(cw, `FBD_CW_JOG1) && !cw_bit(cw, `FBD_CW_JOG2)) begin
      jog_next = fbd_pkg::FBD_SEL_NONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst)
      jog_sel_reg <= fbd_pkg::FBD_SEL_NONE;
    else if (ce)
      jog_sel_reg <= jog_next;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      jog1_active <= 1'b0;
      jog2_active <= 1'b0;
    end else if (ce) begin
      jog1_active <= jog_next == fbd_pkg::FBD_SEL_JOG1;
      jog2_active <= jog_next == fbd_pkg::FBD_SEL_JOG2;
    end
  end

  // edge memories for enable drop, reset edges and the ON edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fb_en_last_reg <= 1'b0;
      frst_last_reg <= 1'b0;
      ack_last_reg <= 1'b0;
      on_last_reg <= 1'b0;
    end else if (ce) begin
      fb_en_last_reg <= fb_en;
      frst_last_reg <= simple_command_word[`FBD_SC_FRST];
      ack_last_reg <= cw_bit(cw, `FBD_CW_FAULT_ACK);
      on_last_reg <= cw_bit(cw, `FBD_CW_ON);
    end
  end

  // a new fault wins over a reset edge in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst)
      fault_reg <= 1'b0;
    else if (ce) begin
      if (fault_in || timeout)
        fault_reg <= 1'b1;
      else if (fault_reset)
        fault_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst)
      fault_reset <= 1'b0;
    else if (ce) begin
      if (simple_mode)
        fault_reset <= simple_command_word[`FBD_SC_FRST] &&
          !frst_last_reg;
      else
        fault_reset <= fb_en && cw_bit(cw, `FBD_CW_FAULT_ACK) &&
          !ack_last_reg;
    end
  end

  // inhibit: releases, then OFF, then ON; stops or fault re-arm it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      inhibit_reg <= 1'b1;
      released_reg <= 1'b0;
    end else if (ce) begin
      if (fault_reg || (fb_en && (!cw_bit(cw, `FBD_CW_COAST_N) ||
          !cw_bit(cw, `FBD_CW_QSTOP_N)))) begin
        inhibit_reg <= 1'b1;
        released_reg <= 1'b0;
      end else if (fb_en && !cw_bit(cw, `FBD_CW_ON)) begin
        released_reg <= 1'b1;
      end else if (fb_en && released_reg && cw_bit(cw, `FBD_CW_ON) &&
          !on_last_reg) begin
        inhibit_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      run_request <= 1'b0;
      direction_ccw <= 1'b0;
      coast_stop <= 1'b0;
      quick_stop <= 1'b0;
    end else if (ce) begin
      if (simple_mode) begin
        // bits 3 to 15 of the simple word are never looked at
        run_request <= simple_command_word[`FBD_SC_RUN];
        direction_ccw <= simple_command_word[`FBD_SC_DIR];
        coast_stop <= 1'b0;
        quick_stop <= 1'b0;
      end else if (fb_en) begin
        run_request <= cw_bit(cw, `FBD_CW_START) && !inhibit_reg &&
          cw_bit(cw, `FBD_CW_ON);
        direction_ccw <= 1'b0;
        coast_stop <= !cw_bit(cw, `FBD_CW_COAST_N);
        quick_stop <= !cw_bit(cw, `FBD_CW_QSTOP_N);
      end else begin
        run_request <= 1'b0;
        // enable lost while running forces a coast
        coast_stop <= fb_en_last_reg && modulating;
        quick_stop <= 1'b0;
      end
    end
  end

  assign fault_active = fault_reg;
  assign ready_on = powered_ready && !fault_reg && !inhibit_reg;
  assign ready_run = ready_on && cw_bit(cw, `FBD_CW_ON) && fb_en;

  always_ff @(posedge sys_clk) begin
    if (rst)
      fieldbus_state_word <= `FBD_WORD_RESET;
    else if (ce) begin
      fieldbus_state_word <= `FBD_WORD_RESET;
      fieldbus_state_word[`FBD_SW_RDY_ON] <= ready_on;
      fieldbus_state_word[`FBD_SW_RDY_RUN] <= ready_run;
      fieldbus_state_word[`FBD_SW_RUNNING] <= running_ok;
      fieldbus_state_word[`FBD_SW_FAULT] <= fault_reg;
      fieldbus_state_word[`FBD_SW_COAST_N] <= !coast_stop;
      fieldbus_state_word[`FBD_SW_QSTOP_N] <= !quick_stop;
      fieldbus_state_word[`FBD_SW_INHIBIT] <= inhibit_reg;
      fieldbus_state_word[`FBD_SW_WARN] <= warning_in;
      fieldbus_state_word[`FBD_SW_AT_REF] <= at_reference;
      fieldbus_state_word[`FBD_SW_FB_ACT] <= fb_en && fieldbus_place;
      fieldbus_state_word[`FBD_SW_ABOVE] <= above_limit;
      fieldbus_state_word[`FBD_SW_ECHO] <= cw_bit(cw, `FBD_CW_ALIVE);
    end
  end
endmodule

//--- tb/fbd_chk_properties.sv
// concurrent checks on the command/status block ports
`timescale 1ns/100ps
module fbd_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [15:0] fieldbus_command_word,
  input wire logic [15:0] simple_command_word,
  input wire logic simple_mode,
  input wire logic fieldbus_place,
  input wire logic modulating,
  input wire logic flux_ready,
  input wire logic brake_feedback_used,
  input wire logic brake_open,
  input wire logic warning_in,
  input wire logic fault_in,
  input wire logic [15:0] alive_pulse_timeout_setting,
  input wire logic [15:0] fieldbus_state_word,
  input wire logic coast_stop,
  input wire logic fault_reset,
  input wire logic fault_active,
  input wire logic alive_fault
);
  wire [15:0] w = fieldbus_state_word;
  wire [15:0] c = fieldbus_command_word;
  logic up_reg;
  // past values taken during reset are not trusted
  always_ff @(posedge sys_clk) begin
    up_reg <= !rst;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst || !ce);
  a_echo_follow:
    assert property (up_reg |-> w[15] == $past(c[11]))
    else $error("echo bit wrong");
  a_unused_zero:
    assert property (w[14:11] == 4'h0) else $error("unused bits set");
  a_warn_follow:
    assert property (up_reg |-> w[7] == $past(warning_in))
    else $error("warning bit wrong");
  a_fb_active:
    assert property (up_reg |->
      w[9] == $past(c[10] && !simple_mode && fieldbus_place))
    else $error("control active bit wrong");
  a_fault_bit:
    assert property (up_reg |-> w[3] == $past(fault_active))
    else $error("fault bit wrong");
  a_fault_set:
    assert property (fault_in |=> fault_active) else $error("fault missed");
  a_running_needs:
    assert property (up_reg && w[2] |-> $past(modulating && flux_ready
      && (!brake_feedback_used || brake_open))) else $error("running early");
  a_reset_pulse:
    assert property (fault_reset |=> !fault_reset) else $error("long reset");
  a_simple_edge:
    assert property (up_reg && simple_mode && $rose(simple_command_word[2])
      |=> fault_reset) else $error("reset edge missed");
  a_coast_drop:
    assert property (up_reg && !simple_mode && $fell(c[10]) && modulating
      && $past(modulating) |=> coast_stop) else $error("no coast stop");
  a_stop_bits:
    assert property (up_reg && $past(up_reg) &&
      $past(c[10] && !simple_mode, 2) |->
      w[5:4] == $past(c[2:1], 2)) else $error("stop bits wrong");
  a_watch_off:
    assert property (up_reg && $past(alive_pulse_timeout_setting) == 16'h0000
      |-> !alive_fault) else $error("watchdog while off");
endmodule
bind fbd_cmd_status fbd_chk u_chk (.*);

//--- tb/fbd_plc_model.sv
// fieldbus master model: passes the bench word and toggles the alive bit
`timescale 1ns/100ps
module fbd_plc_model #(
  parameter int HALF_CYCLES = 20
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] word_in,
  output logic [15:0] fieldbus_command_word
);
  logic alive_reg;
  int cnt_reg;
  // a live master never lets the pulse rest
  always_ff @(negedge sys_clk) begin
    if (rst) begin
      alive_reg <= 1'b0;
      cnt_reg <= 0;
    end else if (cnt_reg == HALF_CYCLES - 1) begin
      alive_reg <= !alive_reg;
      cnt_reg <= 0;
    end else begin
      cnt_reg <= cnt_reg + 1;
    end
  end
  assign fieldbus_command_word = {word_in[15:12], alive_reg, word_in[10:0]};
endmodule

//--- tb/fbd_cmd_status_tb_top.sv
// self-checking bench for the command/status block
`timescale 1ns/100ps
`define CHK(a, b) \
  begin \
    n_compared++; \
    if ((a) !== (b)) begin \
      num_errors++; \
      $display("Error %0t: got %h want %h", $time, a, b); \
    end \
  end
module fbd_cmd_status_tb_top;
  typedef struct packed {
    logic [15:0] c;
    logic [7:0] f;
    logic [15:0] a, e, m;
  } fbd_row_type;
  localparam fbd_row_type ROWS [13] = '{
    '{16'h0000, 8'h04, 16'h0000, 16'h0080, 16'h0080},
    '{16'h0000, 8'h00, 16'h0000, 16'h0000, 16'h0080},
    '{16'h0000, 8'h00, 16'h0067, 16'h0100, 16'h0500},
    '{16'h0000, 8'h00, 16'h006a, 16'h0000, 16'h0500},
    '{16'h0000, 8'h00, 16'h0258, 16'h0400, 16'h0500},
    '{16'h0000, 8'h00, 16'hfda8, 16'h0400, 16'h0500},
    '{16'h0400, 8'h00, 16'h0000, 16'h0200, 16'h0230},
    '{16'h0402, 8'h00, 16'h0000, 16'h0210, 16'h0230},
    '{16'h0004, 8'h00, 16'h0000, 16'h0030, 16'h0230},
    '{16'h0406, 8'h60, 16'h0000, 16'h0004, 16'h0004},
    '{16'h0406, 8'h70, 16'h0000, 16'h0000, 16'h0004},
    '{16'h0406, 8'h40, 16'h0000, 16'h0000, 16'h0004},
    '{16'h0406, 8'h78, 16'h0000, 16'h0004, 16'h0004}};
  logic [15:0] jw [7] = '{16'h050f, 16'h050f, 16'h070f, 16'h051f,
    16'h060f, 16'h050f, 16'h050f};
  logic [4:0] jx [7] = '{5'h00, 5'h05, 5'h04, 5'h04, 5'h06, 5'h19, 5'h14};
  logic sys_clk = 0, rst = 1, ce = 1, simple_mode = 0, fieldbus_place = 1;
  logic aux_jog_enable = 0, io_jog_enable = 0, terminal_control = 0;
  logic powered_ready, modulating, flux_ready, brake_feedback_used;
  logic brake_open, warning_in, fault_in, at_zero_speed;
  logic [7:0] fl = 8'h00;
  logic [15:0] cmd = 16'h0000, simple_command_word = 16'h0000;
  logic [15:0] fieldbus_command_word, fieldbus_state_word;
  logic [15:0] alive_pulse_timeout_setting = 16'h0000;
  logic signed [15:0] speed_actual = 16'sh0000, speed_reference = 16'sh0064;
  logic [15:0] speed_tolerance = 16'h0005, upper_speed_threshold = 16'h01f4;
  logic run_request, direction_ccw, coast_stop, quick_stop, fault_reset;
  logic jog1_active, jog2_active, fault_active, alive_fault;
  int num_errors = 0, n_compared = 0;
  assign {powered_ready, modulating, flux_ready, brake_feedback_used,
    brake_open, warning_in, fault_in, at_zero_speed} = fl;
  always #5 sys_clk = !sys_clk;
  fbd_plc_model u_plc (
    .sys_clk(sys_clk),
    .rst(rst),
    .word_in(cmd),
    .fieldbus_command_word(fieldbus_command_word)
  );
  fbd_cmd_status #(.TICK_CYCLES(10)) DUT (.*);
  task automatic step(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk_reset();
    `CHK(fieldbus_state_word & 16'h7fff, 16'h0070)
  endtask
  task automatic summarize();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    summarize();
  end
  initial begin
    step(6);
    rst = 0;
    step(3);
    chk_reset();
    foreach (ROWS[i]) begin
      cmd = ROWS[i].c;
      fl = ROWS[i].f;
      speed_actual = ROWS[i].a;
      step(3);
      `CHK(fieldbus_state_word & ROWS[i].m, ROWS[i].e)
    end
    $display("rows done");
    fl = 8'h81;
    step(3);
    `CHK(fieldbus_state_word[6], 1'b1)
    cmd = 16'h0407;
    step(2);
    `CHK(fieldbus_state_word[6:0], 7'h33)
    `CHK({run_request, quick_stop}, 2'b00)
    $display("inhibit done");
    // jog only starts from a stopped drive, so each case begins idle
    for (int k = 0; k < 7; k++) begin
      cmd = 16'h0407;
      {terminal_control, io_jog_enable, aux_jog_enable} = jx[k][4:2];
      step(3);
      cmd = jw[k];
      step(3);
      `CHK({jog2_active, jog1_active}, jx[k][1:0])
    end
    $display("jog done");
    cmd = 16'h0407;
    fl = 8'he1;
    step(3);
    `CHK(coast_stop, 1'b0)
    cmd = 16'h0007;
    step(1);
    `CHK(coast_stop, 1'b1)
    step(1);
    `CHK(coast_stop, 1'b0)
    $display("coast done");
    fl = 8'h02;
    step(2);
    fl = 8'h00;
    step(3);
    `CHK(fieldbus_state_word[3], 1'b1)
    simple_mode = 1;
    simple_command_word = 16'h0004;
    step(1);
    `CHK(fault_reset, 1'b1)
    step(3);
    `CHK({fault_reset, fieldbus_state_word[3]}, 2'b00)
    for (int k = 0; k < 3; k++) begin
      simple_command_word = k == 0 ? 16'h0003 : k == 1 ? 16'hfff8 : 16'h0001;
      step(2);
      `CHK({run_request, direction_ccw}, k == 1 ? 2'b00 : {1'b1, k == 0})
    end
    $display("simple done");
    simple_mode = 0;
    fieldbus_place = 0;
    cmd = 16'h0400;
    step(2);
    `CHK(fieldbus_state_word[9], 1'b0)
    // model toggles every 20 cycles: 3 ms of 10 cycles is enough
    alive_pulse_timeout_setting = 16'h0003;
    step(60);
    `CHK({alive_fault, fault_active}, 2'b00)
    alive_pulse_timeout_setting = 16'h0001;
    step(25);
    `CHK({fault_active, fieldbus_state_word[3]}, 2'b11)
    alive_pulse_timeout_setting = 16'h0000;
    step(3);
    `CHK(alive_fault, 1'b0)
    $display("watchdog done");
    cmd = 16'h0000;
    rst = 1;
    step(6);
    rst = 0;
    step(3);
    chk_reset();
    $display("reset done");
    summarize();
  end
endmodule
